// ==== ifmu_regs.vh ====
`ifndef IFMU_REGS_VH
`define IFMU_REGS_VH
// register offsets on the 16-bit I/O address bus
`define IFMU_ADDR_KEY0_SEL 16'hff20
`define IFMU_ADDR_KEY0_CMP 16'hff22
`define IFMU_ADDR_KEY1_SEL 16'hff24
`define IFMU_ADDR_KEY1_CMP 16'hff26
`define IFMU_ADDR_KEY2_SEL 16'hff28
`define IFMU_ADDR_KEY2_CMP 16'hff2a
`define IFMU_ADDR_TMR_EN 16'hffe2
`define IFMU_ADDR_SER_EN 16'hffe3
`define IFMU_ADDR_KEY0_EN 16'hffe4
`define IFMU_ADDR_KEY12_EN 16'hffe5
`define IFMU_ADDR_TAP_EN 16'hffe6
`define IFMU_ADDR_ADC_EN 16'hffe7
`define IFMU_ADDR_TMR_FLG 16'hfff2
`define IFMU_ADDR_SER_FLG 16'hfff3
`define IFMU_ADDR_KEY0_FLG 16'hfff4
`define IFMU_ADDR_KEY12_FLG 16'hfff5
`define IFMU_ADDR_TAP_FLG 16'hfff6
`define IFMU_ADDR_ADC_FLG 16'hfff7
// reset values
`define IFMU_RST_SEL 4'h0
`define IFMU_RST_CMP 4'hf
`define IFMU_RST_EN 4'h0
`define IFMU_RST_FLG 4'h0
// vector low nibbles, highest priority first
`define IFMU_VEC_WDT 4'h0
`define IFMU_VEC_TMR 4'h4
`define IFMU_VEC_SER 4'h6
`define IFMU_VEC_KEY0 4'h8
`define IFMU_VEC_KEY12 4'ha
`define IFMU_VEC_TAP 4'hc
`define IFMU_VEC_ADC 4'he
`endif

// ==== ifmu_key_detect.v ====
`timescale 1ns/100ps
`include "ifmu_regs.vh"
// ****************************************
// key group change detector
// ****************************************
module ifmu_key_detect #(
  parameter WIDTH = 4
) (
  input wire sys_clk_i, // system clock
  input wire sys_rst_i, // synchronous reset, high
  input wire clk_en_i, // clock enable
  input wire [WIDTH-1:0] pins_i, // asynchronous key pins
  input wire [WIDTH-1:0] select_i, // per-pin interrupt select
  input wire [WIDTH-1:0] compare_i, // per-pin compare level
  output wire event_o // one-cycle group event
);
  reg [WIDTH-1:0] sync1_ff;
  reg [WIDTH-1:0] sync2_ff;
  reg match_ff;
  wire [WIDTH-1:0] hit;
  wire match;
  // pins pass two flops before any logic reads them
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sync1_ff <= {WIDTH{1'b0}};
      sync2_ff <= {WIDTH{1'b0}};
      match_ff <= 1'b1;
    end else if (clk_en_i) begin
      sync1_ff <= pins_i;
      sync2_ff <= sync1_ff;
      match_ff <= match;
    end
  end
  // per-pin mismatch against compare level, gated by select
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      assign hit[g] = select_i[g] & (sync2_ff[g] ^ compare_i[g]);
    end
  endgenerate
  // event when the selected pins leave the compare pattern
  assign match = ~|hit;
  assign event_o = clk_en_i & match_ff & ~match;
endmodule

// ==== ifmu_top.v ====
`timescale 1ns/100ps
`include "ifmu_regs.vh"
// Overview of operation
// R1: serial done flag, write-one clear, reset zero
// R2: key group 0 flag at bit 0
// R3: key group 1 bit 0, group 2 bit 1
// R4: clock taps: 1Hz b3, 2Hz b2, 8Hz b1, 16Hz b0
// R5: adc done flag at bit 0
// R6: unimplemented bits read zero, ignore writes
// R7: timer 1 enable bit 1, timer 0 bit 0
// R8: serial enable bit gates serial flag
// R9: key compare and select bits per pin
// R10: four tap enables aligned with tap flags
// R11: adc enable bit gates adc flag
// R12: flags set regardless of enable bits
// R13: uncleared enabled flag requests again
// R14: after reset block all until both pointers written
// R15: rewriting one pointer blocks until the other
// R16: request needs flag, enable, and cpu enable
// R17: reset clears all enable bits
// R18: watchdog request is non-maskable, no flag
// R19: fixed priority vectoring, watchdog highest
module ifmu_top (
  input wire sys_clk_i, // system clock, 200 MHz
  input wire sys_rst_i, // initial reset, synchronous high
  input wire clk_en_i, // clock enable, freezes state when low
  input wire [15:0] addr_i, // i/o address
  input wire [3:0] wdata_i, // write data nibble
  input wire wr_i, // write strobe
  input wire rd_i, // read strobe
  output reg [3:0] rdata_o, // read data, registered
  input wire timer0_evt_i, // timer 0 underflow pulse
  input wire timer1_evt_i, // timer 1 underflow pulse
  input wire serial_evt_i, // serial 8-bit transfer done pulse
  input wire adc_evt_i, // adc conversion done pulse
  input wire [3:0] clock_taps_i, // taps {1hz,2hz,8hz,16hz}
  input wire [3:0] key_group0_i, // key group 0 pins
  input wire [3:0] key_group1_i, // key group 1 pins
  input wire key_group2_i, // key group 2 pin
  input wire wdt_evt_i, // watchdog non-maskable pulse
  input wire wide_sp_wr_i, // wide stack pointer written
  input wire narrow_sp_wr_i, // narrow stack pointer written
  input wire cpu_int_en_i, // cpu interrupt enable status
  input wire irq_ack_i, // cpu takes the request
  output wire irq_o, // request to cpu
  output wire nmi_o, // non-maskable request pending
  output wire [3:0] irq_vector_o // vector low nibble
);
  // ****************************************
  // register state
  // ****************************************
  reg [3:0] key_group0_select_bits_ff;
  reg [3:0] key_group0_compare_bits_ff;
  reg [3:0] key_group1_select_ff;
  reg [3:0] key_group1_compare_ff;
  reg key_group2_select_ff;
  reg key_group2_compare_ff;
  reg timer1_enable_bit_ff;
  reg timer0_enable_bit_ff;
  reg serial_enable_bit_ff;
  reg key_group0_enable_bit_ff;
  reg key_group1_enable_bit_ff;
  reg key_group2_enable_bit_ff;
  reg [3:0] clock_tap_enable_bits_ff;
  reg adc_enable_bit_ff;
  reg timer1_event_flag_ff;
  reg timer0_event_flag_ff;
  reg serial_done_flag_ff;
  reg key_group0_flag_ff;
  reg key_group1_flag_ff;
  reg key_group2_flag_ff;
  reg [3:0] tap_flags_ff; // {1hz,2hz,8hz,16hz}
  reg adc_done_flag_ff;
  reg wide_sp_set_ff;
  reg narrow_sp_set_ff;
  reg nmi_pend_ff;
  reg [3:0] tap_s1_ff;
  reg [3:0] tap_s2_ff;
  reg [3:0] tap_s3_ff;
  reg [3:0] vector_ff;
  reg [3:0] nxt_rdata;
  reg [3:0] nxt_vector;
  wire we;
  wire [3:0] tap_fall;
  wire key0_evt;
  wire key1_evt;
  wire key2_evt;
  wire unlocked;
  wire tmr_req;
  wire ser_req;
  wire key0_req;
  wire key12_req;
  wire tap_req;
  wire adc_req;
  wire any_req;
  assign we = wr_i & clk_en_i;
  // ****************************************
  // key group detectors
  // ****************************************
  ifmu_key_detect #(.WIDTH(4)) u_key0 (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .pins_i(key_group0_i),
    .select_i(key_group0_select_bits_ff), // R9
    .compare_i(key_group0_compare_bits_ff),
    .event_o(key0_evt)
  );
  ifmu_key_detect #(.WIDTH(4)) u_key1 (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .pins_i(key_group1_i),
    .select_i(key_group1_select_ff),
    .compare_i(key_group1_compare_ff),
    .event_o(key1_evt)
  );
  ifmu_key_detect #(.WIDTH(1)) u_key2 (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .pins_i(key_group2_i),
    .select_i(key_group2_select_ff),
    .compare_i(key_group2_compare_ff),
    .event_o(key2_evt)
  );
  // ****************************************
  // clock tap falling edges
  // ****************************************
  // taps come from the slow timer domain, so synchronise first
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tap_s1_ff <= 4'h0;
      tap_s2_ff <= 4'h0;
      tap_s3_ff <= 4'h0;
    end else if (clk_en_i) begin
      tap_s1_ff <= clock_taps_i;
      tap_s2_ff <= tap_s1_ff;
      tap_s3_ff <= tap_s2_ff;
    end
  end
  assign tap_fall = tap_s3_ff & ~tap_s2_ff;
  // ****************************************
  // configuration and enable registers
  // ****************************************
  // only implemented bits are stored; the rest drop on write
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      key_group0_select_bits_ff <= `IFMU_RST_SEL;
      key_group0_compare_bits_ff <= `IFMU_RST_CMP;
      key_group1_select_ff <= `IFMU_RST_SEL;
      key_group1_compare_ff <= `IFMU_RST_CMP;
      key_group2_select_ff <= 1'b0;
      key_group2_compare_ff <= 1'b1;
      timer1_enable_bit_ff <= 1'b0; // R17
      timer0_enable_bit_ff <= 1'b0;
      serial_enable_bit_ff <= 1'b0;
      key_group0_enable_bit_ff <= 1'b0;
      key_group1_enable_bit_ff <= 1'b0;
      key_group2_enable_bit_ff <= 1'b0;
      clock_tap_enable_bits_ff <= `IFMU_RST_EN;
      adc_enable_bit_ff <= 1'b0;
    end else if (we) begin
      case (addr_i)
        `IFMU_ADDR_KEY0_SEL: key_group0_select_bits_ff <= wdata_i; // R9
        `IFMU_ADDR_KEY0_CMP: key_group0_compare_bits_ff <= wdata_i; // R9
        `IFMU_ADDR_KEY1_SEL: key_group1_select_ff <= wdata_i; // R9
        `IFMU_ADDR_KEY1_CMP: key_group1_compare_ff <= wdata_i; // R9
        `IFMU_ADDR_KEY2_SEL: key_group2_select_ff <= wdata_i[0]; // R9
        `IFMU_ADDR_KEY2_CMP: key_group2_compare_ff <= wdata_i[0]; // R6
        `IFMU_ADDR_TMR_EN: begin
          timer1_enable_bit_ff <= wdata_i[1]; // R7
          timer0_enable_bit_ff <= wdata_i[0]; // R7
        end
        `IFMU_ADDR_SER_EN: serial_enable_bit_ff <= wdata_i[0]; // R8
        `IFMU_ADDR_KEY0_EN: key_group0_enable_bit_ff <= wdata_i[0];
        `IFMU_ADDR_KEY12_EN: begin
          key_group2_enable_bit_ff <= wdata_i[1];
          key_group1_enable_bit_ff <= wdata_i[0];
        end
        `IFMU_ADDR_TAP_EN: clock_tap_enable_bits_ff <= wdata_i; // R10
        `IFMU_ADDR_ADC_EN: adc_enable_bit_ff <= wdata_i[0]; // R11
        default: ;
      endcase
    end
  end
  // ****************************************
  // event flags, write one to clear
  // ****************************************
  // set term is ored last so an event in the clear cycle wins
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      timer1_event_flag_ff <= 1'b0;
      timer0_event_flag_ff <= 1'b0;
      serial_done_flag_ff <= 1'b0; // R1
      key_group0_flag_ff <= 1'b0; // R2
      key_group1_flag_ff <= 1'b0; // R3
      key_group2_flag_ff <= 1'b0;
      tap_flags_ff <= `IFMU_RST_FLG; // R4
      adc_done_flag_ff <= 1'b0; // R5
    end else if (clk_en_i) begin
      timer1_event_flag_ff <= (timer1_event_flag_ff &
        ~(we & addr_i == `IFMU_ADDR_TMR_FLG & wdata_i[1])) | timer1_evt_i; // R12
      timer0_event_flag_ff <= (timer0_event_flag_ff &
        ~(we & addr_i == `IFMU_ADDR_TMR_FLG & wdata_i[0])) | timer0_evt_i;
      serial_done_flag_ff <= (serial_done_flag_ff &
        ~(we & addr_i == `IFMU_ADDR_SER_FLG & wdata_i[0])) | serial_evt_i; // R1
      key_group0_flag_ff <= (key_group0_flag_ff &
        ~(we & addr_i == `IFMU_ADDR_KEY0_FLG & wdata_i[0])) | key0_evt; // R2
      key_group1_flag_ff <= (key_group1_flag_ff &
        ~(we & addr_i == `IFMU_ADDR_KEY12_FLG & wdata_i[0])) | key1_evt; // R3
      key_group2_flag_ff <= (key_group2_flag_ff &
        ~(we & addr_i == `IFMU_ADDR_KEY12_FLG & wdata_i[1])) | key2_evt; // R3
      tap_flags_ff <= (tap_flags_ff &
        ~({4{we & addr_i == `IFMU_ADDR_TAP_FLG}} & wdata_i)) | tap_fall; // R4
      adc_done_flag_ff <= (adc_done_flag_ff &
        ~(we & addr_i == `IFMU_ADDR_ADC_FLG & wdata_i[0])) | adc_evt_i; // R5
    end
  end
  // ****************************************
  // stack pointer interlock
  // ****************************************
  // rewriting a pointer whose mark is set drops the other's mark; a pair rearms
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wide_sp_set_ff <= 1'b0; // R14
      narrow_sp_set_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (wide_sp_wr_i & narrow_sp_wr_i) begin
        wide_sp_set_ff <= 1'b1;
        narrow_sp_set_ff <= 1'b1;
      end else if (wide_sp_wr_i) begin
        wide_sp_set_ff <= 1'b1;
        narrow_sp_set_ff <= narrow_sp_set_ff & ~wide_sp_set_ff; // R15
      end else if (narrow_sp_wr_i) begin
        narrow_sp_set_ff <= 1'b1;
        wide_sp_set_ff <= wide_sp_set_ff & ~narrow_sp_set_ff; // R15
      end
    end
  end
  assign unlocked = wide_sp_set_ff & narrow_sp_set_ff; // R14
  // ****************************************
  // watchdog request latch
  // ****************************************
  // held until the cpu takes it; no software-visible flag
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      nmi_pend_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (wdt_evt_i) begin
        nmi_pend_ff <= 1'b1; // R18
      end else if (irq_ack_i & unlocked & nmi_pend_ff) begin
        nmi_pend_ff <= 1'b0;
      end
    end
  end
  // ****************************************
  // request gating and priority
  // ****************************************
  // levels, not pulses: an uncleared flag keeps requesting
  assign tmr_req = (timer1_event_flag_ff & timer1_enable_bit_ff) |
    (timer0_event_flag_ff & timer0_enable_bit_ff); // R16
  assign ser_req = serial_done_flag_ff & serial_enable_bit_ff; // R8
  assign key0_req = key_group0_flag_ff & key_group0_enable_bit_ff;
  assign key12_req = (key_group1_flag_ff & key_group1_enable_bit_ff) |
    (key_group2_flag_ff & key_group2_enable_bit_ff);
  assign tap_req = |(tap_flags_ff & clock_tap_enable_bits_ff); // R10
  assign adc_req = adc_done_flag_ff & adc_enable_bit_ff; // R11
  assign any_req = tmr_req | ser_req | key0_req | key12_req | tap_req | adc_req;
  assign nmi_o = nmi_pend_ff & unlocked; // R18
  assign irq_o = unlocked & (nmi_pend_ff | (cpu_int_en_i & any_req)); // R13
  // fixed priority encoder, watchdog first
  always @* begin
    nxt_vector = vector_ff;
    if (nmi_pend_ff) begin
      nxt_vector = `IFMU_VEC_WDT; // R19
    end else if (tmr_req) begin
      nxt_vector = `IFMU_VEC_TMR;
    end else if (ser_req) begin
      nxt_vector = `IFMU_VEC_SER;
    end else if (key0_req) begin
      nxt_vector = `IFMU_VEC_KEY0;
    end else if (key12_req) begin
      nxt_vector = `IFMU_VEC_KEY12;
    end else if (tap_req) begin
      nxt_vector = `IFMU_VEC_TAP;
    end else if (adc_req) begin
      nxt_vector = `IFMU_VEC_ADC; // R19
    end
  end
  // vector registered so the vector output comes from a flop
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      vector_ff <= `IFMU_VEC_WDT;
    end else if (clk_en_i) begin
      vector_ff <= nxt_vector;
    end
  end
  assign irq_vector_o = vector_ff;
  // ****************************************
  // read mux
  // ****************************************
  always @* begin
    nxt_rdata = 4'h0; // R6
    case (addr_i)
      `IFMU_ADDR_KEY0_SEL: nxt_rdata = key_group0_select_bits_ff;
      `IFMU_ADDR_KEY0_CMP: nxt_rdata = key_group0_compare_bits_ff;
      `IFMU_ADDR_KEY1_SEL: nxt_rdata = key_group1_select_ff;
      `IFMU_ADDR_KEY1_CMP: nxt_rdata = key_group1_compare_ff;
      `IFMU_ADDR_KEY2_SEL: nxt_rdata = {3'h0, key_group2_select_ff};
      `IFMU_ADDR_KEY2_CMP: nxt_rdata = {3'h0, key_group2_compare_ff};
      `IFMU_ADDR_TMR_EN: nxt_rdata = {2'h0, timer1_enable_bit_ff, timer0_enable_bit_ff};
      `IFMU_ADDR_SER_EN: nxt_rdata = {3'h0, serial_enable_bit_ff};
      `IFMU_ADDR_KEY0_EN: nxt_rdata = {3'h0, key_group0_enable_bit_ff};
      `IFMU_ADDR_KEY12_EN:
        nxt_rdata = {2'h0, key_group2_enable_bit_ff, key_group1_enable_bit_ff};
      `IFMU_ADDR_TAP_EN: nxt_rdata = clock_tap_enable_bits_ff;
      `IFMU_ADDR_ADC_EN: nxt_rdata = {3'h0, adc_enable_bit_ff};
      `IFMU_ADDR_TMR_FLG: nxt_rdata = {2'h0, timer1_event_flag_ff, timer0_event_flag_ff};
      `IFMU_ADDR_SER_FLG: nxt_rdata = {3'h0, serial_done_flag_ff};
      `IFMU_ADDR_KEY0_FLG: nxt_rdata = {3'h0, key_group0_flag_ff};
      `IFMU_ADDR_KEY12_FLG: nxt_rdata = {2'h0, key_group2_flag_ff, key_group1_flag_ff};
      `IFMU_ADDR_TAP_FLG: nxt_rdata = tap_flags_ff;
      `IFMU_ADDR_ADC_FLG: nxt_rdata = {3'h0, adc_done_flag_ff};
      default: nxt_rdata = 4'h0;
    endcase
  end
  // read data held between reads
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 4'h0;
    end else if (clk_en_i & rd_i) begin
      rdata_o <= nxt_rdata;
    end
  end
endmodule

// ==== ifmu_chk.sv ====
`timescale 1ns/100ps
// ******************************
// interlock and request checker
// ******************************
module ifmu_chk (
  input wire sys_clk_i, // clock
  input wire sys_rst_i, // reset
  input wire clk_en_i, // enable
  input wire [15:0] addr_i, // address
  input wire [3:0] wdata_i, // write data
  input wire wr_i, // write
  input wire rd_i, // read
  input wire [3:0] rdata_o, // read data
  input wire serial_evt_i, // serial done
  input wire wdt_evt_i, // watchdog
  input wire wide_sp_wr_i, // wide pointer
  input wire narrow_sp_wr_i, // narrow pointer
  input wire cpu_int_en_i, // cpu enable
  input wire irq_ack_i, // acknowledge
  input wire irq_o, // request
  input wire nmi_o, // nmi
  input wire [3:0] irq_vector_o // vector
);
  reg wide_ff;
  reg narrow_ff;
  reg ser_en_ff;
  wire open_w = wide_ff & narrow_ff;
  wire sp_w = wide_sp_wr_i | narrow_sp_wr_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // shadow interlock; a lone rewrite while open closes it again
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wide_ff <= 1'b0;
      narrow_ff <= 1'b0;
      ser_en_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (wide_sp_wr_i)
        wide_ff <= 1'b1;
      else if (narrow_sp_wr_i && open_w)
        wide_ff <= 1'b0;
      if (narrow_sp_wr_i)
        narrow_ff <= 1'b1;
      else if (wide_sp_wr_i && open_w)
        narrow_ff <= 1'b0;
      if (wr_i && addr_i == 16'hffe3)
        ser_en_ff <= wdata_i[0];
    end
  end
  a_lock_blocks_all: assert property (!open_w |-> !irq_o && !nmi_o)
    else $error("request while interlock closed");
  a_irq_needs_ien: assert property (irq_o && !nmi_o |-> cpu_int_en_i)
    else $error("maskable request without cpu enable");
  a_serial_raises_irq: assert property (serial_evt_i && clk_en_i && ser_en_ff &&
    cpu_int_en_i && open_w && !sp_w |=> irq_o)
    else $error("enabled serial event gave no request");
  a_wdt_sets_nmi: assert property (wdt_evt_i && clk_en_i && open_w && !sp_w &&
    !irq_ack_i |=> nmi_o && irq_o)
    else $error("watchdog event gave no nmi");
  a_nmi_held: assert property (nmi_o && clk_en_i && !irq_ack_i && !sp_w |=> nmi_o)
    else $error("nmi dropped without acknowledge");
  a_nmi_vector_top: assert property (nmi_o && clk_en_i ##1 nmi_o |-> irq_vector_o == 4'h0)
    else $error("nmi vector wrong");
  a_rd_narrow_zero: assert property (rd_i && clk_en_i && addr_i inside {16'hffe3,
    16'hffe4, 16'hffe7, 16'hfff3, 16'hfff4, 16'hfff7} |=> rdata_o[3:1] == 3'h0)
    else $error("unused bits read nonzero");
  a_rd_unmapped_zero: assert property (rd_i && clk_en_i && addr_i[15:8] == 8'h00
    |=> rdata_o == 4'h0)
    else $error("unmapped read nonzero");
  c_unlock: cover property ($rose(open_w));
  c_nmi: cover property ($rose(nmi_o));
  c_irq: cover property (irq_o && !nmi_o);
endmodule
bind ifmu_top ifmu_chk u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .serial_evt_i(serial_evt_i), .wdt_evt_i(wdt_evt_i),
  .wide_sp_wr_i(wide_sp_wr_i), .narrow_sp_wr_i(narrow_sp_wr_i),
  .cpu_int_en_i(cpu_int_en_i), .irq_ack_i(irq_ack_i), .irq_o(irq_o), .nmi_o(nmi_o),
  .irq_vector_o(irq_vector_o));

// ==== ifmu_cpu_model.sv ====
`timescale 1ns/100ps
// ******************************
// cpu core side of the request lines
// ******************************
module ifmu_cpu_model #(
  parameter ACK_DELAY = 4
) (
  input wire sys_clk_i, // clock
  input wire nmi_i, // nmi pending
  output reg irq_ack_o, // acknowledge
  output reg wide_sp_wr_o, // wide pointer write
  output reg narrow_sp_wr_o, // narrow pointer write
  output reg cpu_int_en_o // interrupt enable status
);
  integer wait_cnt;
  // quiet outputs from time zero
  initial begin
    irq_ack_o = 1'b0;
    wide_sp_wr_o = 1'b0;
    narrow_sp_wr_o = 1'b0;
    cpu_int_en_o = 1'b0;
    wait_cnt = 0;
  end
  // a slow core: takes a pending nmi only after some cycles
  always @(posedge sys_clk_i) begin
    if (nmi_i && !irq_ack_o && wait_cnt == ACK_DELAY - 1) begin
      irq_ack_o <= 1'b1;
      wait_cnt <= 0;
    end else begin
      irq_ack_o <= 1'b0;
      wait_cnt <= (nmi_i && !irq_ack_o) ? wait_cnt + 1 : 0;
    end
  end
  // one pointer write per call; software follows with the other
  task sp_write(input logic wide, input logic narrow);
    @(posedge sys_clk_i);
    wide_sp_wr_o <= wide;
    narrow_sp_wr_o <= narrow;
    @(posedge sys_clk_i);
    wide_sp_wr_o <= 1'b0;
    narrow_sp_wr_o <= 1'b0;
  endtask
  task set_ien(input logic v);
    @(posedge sys_clk_i);
    cpu_int_en_o <= v;
  endtask
endmodule

// ==== tb_interrupt_flag_mask_unit.sv ====
`timescale 1ns/100ps
// ******************************
// flag and mask bench
// ******************************
module tb_interrupt_flag_mask_unit;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [3:0] wdata_i = 4'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic clk_en = 1'b1;
  logic tmr0 = 1'b0, tmr1 = 1'b0, ser = 1'b0, adc = 1'b0, wdt = 1'b0;
  logic [3:0] taps = 4'hf, key0 = 4'hf, key1 = 4'hf;
  logic key2 = 1'b1;
  wire [3:0] rdata_o, vec_o;
  wire irq_o, nmi_o, ack, wide_wr, narrow_wr, ien;
  int err_total = 0;
  int comparisons = 0;
  logic [15:0] ra [18] = '{16'hff20, 16'hff22, 16'hff24, 16'hff26, 16'hff28, 16'hff2a,
    16'hffe2, 16'hffe3, 16'hffe4, 16'hffe5, 16'hffe6, 16'hffe7,
    16'hfff2, 16'hfff3, 16'hfff4, 16'hfff5, 16'hfff6, 16'hfff7};
  localparam [71:0] RST_V = 72'h0f0f01_000000_000000;
  localparam [71:0] WR_M = 72'hffff11_3113f1_000000;
  always #2.5 sys_clk_i = ~sys_clk_i;
  ifmu_top u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timer0_evt_i(tmr0), .timer1_evt_i(tmr1), .serial_evt_i(ser), .adc_evt_i(adc),
    .clock_taps_i(taps), .key_group0_i(key0), .key_group1_i(key1), .key_group2_i(key2),
    .wdt_evt_i(wdt), .wide_sp_wr_i(wide_wr), .narrow_sp_wr_i(narrow_wr),
    .cpu_int_en_i(ien), .irq_ack_i(ack), .irq_o(irq_o), .nmi_o(nmi_o),
    .irq_vector_o(vec_o));
  ifmu_cpu_model #(.ACK_DELAY(4)) u_cpu (.sys_clk_i(sys_clk_i), .nmi_i(nmi_o),
    .irq_ack_o(ack), .wide_sp_wr_o(wide_wr), .narrow_sp_wr_o(narrow_wr),
    .cpu_int_en_o(ien));
  // compare and count
  task chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // rdata lands one edge after the strobe, so look at the next low phase
  task rd(input logic [15:0] a, input logic [3:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk($sformatf("rd %h", a), rdata_o, e);
  endtask
  task sig(input logic i, input logic n);
    @(negedge sys_clk_i);
    chk("irq nmi", {2'h0, irq_o, nmi_o}, {2'h0, i, n});
  endtask
  task vec(input logic [3:0] e);
    repeat (2) @(negedge sys_clk_i);
    chk("vector", vec_o, e);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // cut a hang well past the expected few hundred cycles
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    err_total++;
    report_and_stop;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 18; i++)
      rd(ra[i], RST_V[4*(17-i) +: 4]);
    rd(16'h0010, 4'h0);
    $display("test reset values done");
    for (int i = 0; i < 18; i++) begin
      wr(ra[i], 4'hf);
      rd(ra[i], WR_M[4*(17-i) +: 4]);
    end
    wr(16'h0010, 4'hf);
    rd(16'h0010, 4'h0);
    // a write while the clock enable is low must leave the mask untouched
    @(posedge sys_clk_i);
    clk_en <= 1'b0;
    wr(16'hffe3, 4'h0);
    @(posedge sys_clk_i);
    clk_en <= 1'b1;
    rd(16'hffe3, 4'h1);
    $display("test access done");
    // every flagged source fires with all enables cleared; the watchdog is not fired here
    for (int i = 6; i < 12; i++)
      wr(ra[i], 4'h0);
    @(posedge sys_clk_i);
    {tmr0, tmr1, ser, adc} <= 4'hf;
    taps <= 4'h0;
    key0 <= 4'he;
    key1 <= 4'he;
    key2 <= 1'b0;
    @(posedge sys_clk_i);
    {tmr0, tmr1, ser, adc} <= 4'h0;
    repeat (6) @(posedge sys_clk_i);
    for (int i = 12; i < 18; i++)
      rd(ra[i], (i == 12 || i == 15) ? 4'h3 : (i == 16 ? 4'hf : 4'h1));
    sig(1'b0, 1'b0);
    wr(16'hfff6, 4'h5);
    rd(16'hfff6, 4'ha);
    wr(16'hfff3, 4'h0);
    rd(16'hfff3, 4'h1);
    for (int i = 12; i < 18; i++) begin
      wr(ra[i], 4'hf);
      rd(ra[i], 4'h0);
    end
    $display("test flags done");
    // interlock, gating and priority
    wr(16'hffe3, 4'h1);
    u_cpu.set_ien(1'b1);
    @(posedge sys_clk_i);
    ser <= 1'b1;
    @(posedge sys_clk_i);
    ser <= 1'b0;
    sig(1'b0, 1'b0);
    u_cpu.sp_write(1'b1, 1'b0);
    sig(1'b0, 1'b0);
    u_cpu.sp_write(1'b0, 1'b1);
    sig(1'b1, 1'b0);
    vec(4'h6);
    u_cpu.sp_write(1'b1, 1'b0);
    sig(1'b0, 1'b0);
    u_cpu.sp_write(1'b0, 1'b1);
    sig(1'b1, 1'b0);
    wr(16'hffe7, 4'h1);
    @(posedge sys_clk_i);
    adc <= 1'b1;
    @(posedge sys_clk_i);
    adc <= 1'b0;
    vec(4'h6);
    wr(16'hfff3, 4'h1);
    vec(4'he);
    u_cpu.set_ien(1'b0);
    sig(1'b0, 1'b0);
    u_cpu.set_ien(1'b1);
    sig(1'b1, 1'b0);
    wr(16'hfff7, 4'h1);
    sig(1'b0, 1'b0);
    @(posedge sys_clk_i);
    ser <= 1'b1;
    @(posedge sys_clk_i);
    ser <= 1'b0;
    sig(1'b1, 1'b0);
    u_cpu.set_ien(1'b0);
    @(posedge sys_clk_i);
    wdt <= 1'b1;
    @(posedge sys_clk_i);
    wdt <= 1'b0;
    sig(1'b1, 1'b1);
    vec(4'h0);
    repeat (8) @(posedge sys_clk_i);
    sig(1'b0, 1'b0);
    $display("test requests done");
    report_and_stop;
  end
endmodule
